// ---- hdl/eiic_map.svh ----
// Overview of operation
// R1: Pin-group edge sets that pin's request flag
// R2: Flags survive acceptance; write 0 clears, 1 ignored
// R3: Reset clears pin-group flag register to zero
// R4: Twelve external sources: four dedicated, eight group
// R5: Dedicated pins use first edge select bit
// R6: Dedicated flag needs interrupt port mode set
// R7: Dedicated enable 0 blocks recognition of request
// R8: Dedicated pins 0..3 get vectors 4..7
// R9: Group pins use second edge select bit
// R10: Group enable 0 blocks recognition of request
// R11: All group pins share vector eight
// R12: Group flag sets even in general port use
// R13: 21 internal requests, own flags, vectors 23..9
// R14: Global mask bit 1 masks every request
// R15: Highest priority pending wins, others stay pending
// R16: Accept only with mask 0, else pending
// R17: Finish instruction, then save PC and codes
// R18: Exception entry sets global mask bit
// R19: Make vector address, fetch handler, start there
// R20: Software clears bits only while masked
// R21: Clear colliding with request still takes exception
// R22: Entry takes 1-13, 4, 2, 4, 4 states
// R23: External pins synchronised before edge detection
`ifndef EIIC_MAP_SVH
`define EIIC_MAP_SVH

// Register word offsets (byte addresses)
`define EIIC_OFS_EDGE1      8'h00
`define EIIC_OFS_EDGE2      8'h04
`define EIIC_OFS_PORT_MODE  8'h08
`define EIIC_OFS_ENABLE1    8'h0C
`define EIIC_OFS_ENABLE3    8'h10
`define EIIC_OFS_INT_ENABLE 8'h14
`define EIIC_OFS_FLAGS1     8'h18
`define EIIC_OFS_FLAGS3     8'h1C
`define EIIC_OFS_INT_FLAGS  8'h20
`define EIIC_OFS_STATUS     8'h24

// Source counts
`define EIIC_NUM_DED 4
`define EIIC_NUM_PG  8
`define EIIC_NUM_INT 21
`define EIIC_NUM_SRC 26

// Reset values
`define EIIC_RST_BYTE  8'h00
`define EIIC_RST_WORD  32'h0000_0000

// Vector numbers
`define EIIC_VEC_DED_BASE 5'd4
`define EIIC_VEC_PG       5'd8
`define EIIC_VEC_INT_BASE 5'd9
`define EIIC_VEC_INT_SPAN 15

// Entry timing, in states; one state is one system clock cycle
`define EIIC_SAVE_STATES   4
`define EIIC_VEC_STATES    2
`define EIIC_IFETCH_STATES 4
`define EIIC_INTPROC_STATES 4
`define EIIC_SAVE_CYC    4'(`EIIC_SAVE_STATES - 1)
`define EIIC_VEC_CYC     4'(`EIIC_VEC_STATES - 1)
`define EIIC_IFETCH_CYC  4'(`EIIC_IFETCH_STATES - 1)
`define EIIC_INTPROC_CYC 4'(`EIIC_INTPROC_STATES - 1)

`endif

// ---- hdl/eiic_pkg.sv ----
`include "eiic_map.svh"

package eiic_pkg;

  // Exception entry phases
  typedef enum logic [2:0]
  {
    EIIC_IDLE,
    EIIC_SAVE,
    EIIC_VFETCH,
    EIIC_IFETCH,
    EIIC_INTPROC
  } eiic_phase_t;

  // Whole state of the controller top
  typedef struct packed
  {
    eiic_phase_t                phase;
    logic [3:0]                 cnt;
    logic [4:0]                 vec_num;
    logic [15:0]                handler;
    logic [`EIIC_NUM_DED-1:0]   ded_edge_sel;
    logic [`EIIC_NUM_PG-1:0]    pg_edge_sel;
    logic [`EIIC_NUM_DED-1:0]   port_mode;
    logic [`EIIC_NUM_DED-1:0]   ded_enable;
    logic [`EIIC_NUM_PG-1:0]    pg_enable;
    logic [`EIIC_NUM_INT-1:0]   int_enable;
    logic [`EIIC_NUM_DED-1:0]   ded_flags;
    logic [`EIIC_NUM_PG-1:0]    pg_flags;
    logic [`EIIC_NUM_INT-1:0]   int_flags;
    logic                       ack;
    logic [31:0]                rdata;
    logic                       save_ctx;
    logic                       set_mask;
    logic                       vec_fetch;
    logic [15:0]                vec_addr;
    logic                       handler_start;
  } eiic_state_t;

endpackage : eiic_pkg

// ---- hdl/eiic_edge_detect.sv ----
`timescale 1ns/10ps
`default_nettype none

module eiic_edge_detect #(
  parameter int N = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [N-1:0] i_pin,
  input  wire logic [N-1:0] i_rise_sel,
  output var  logic [N-1:0] o_edge
);

  typedef struct packed
  {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;
  } eiic_edge_state_t;

  eiic_edge_state_t st_reg;
  eiic_edge_state_t st_next;

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser then history
  always_comb
  begin
    st_next      = st_reg;
    st_next.meta = i_pin;             // R23
    st_next.sync = st_reg.meta;       // R23
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////
  // One pulse per selected transition
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_edge
      assign o_edge[g] = (st_reg.sync[g] ^ st_reg.prev[g])
                       & (st_reg.sync[g] == i_rise_sel[g]); // R5 R9
    end
  endgenerate

endmodule : eiic_edge_detect

`default_nettype wire

// ---- hdl/eiic_prio_enc.sv ----
`timescale 1ns/10ps
`default_nettype none

module eiic_prio_enc
  import eiic_pkg::*;
#(
  parameter int N = `EIIC_NUM_SRC
) (
  input  wire logic [N-1:0] i_pending,
  output var  logic         o_valid,
  output var  logic [4:0]   o_vector
);

  // Source index to vector number
  function automatic logic [4:0] src_vector(input int idx);
    if (idx < `EIIC_NUM_DED)
      return `EIIC_VEC_DED_BASE + 5'(idx);                    // R8
    else if (idx == `EIIC_NUM_DED)
      return `EIIC_VEC_PG;                                    // R11
    else
      return `EIIC_VEC_INT_BASE
           + 5'(((idx - `EIIC_NUM_DED - 1) * `EIIC_VEC_INT_SPAN)
                / `EIIC_NUM_INT);                             // R13
  endfunction : src_vector

  ////////////////////////////////////////////////////////////////////
  // Lowest index wins; the rest stay pending in their flags
  always_comb
  begin
    o_valid  = 1'b0;
    o_vector = 5'h00;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (i_pending[i])
      begin
        o_valid  = 1'b1;                                      // R15
        o_vector = src_vector(i);
      end
    end
  end

endmodule : eiic_prio_enc

`default_nettype wire

// ---- hdl/eiic_top.sv ----
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module eiic_top
  import eiic_pkg::*;
(
  input  wire logic                     I_CORE_CLK,
  input  wire logic                     I_RESET,
  input  wire logic                     I_WB_CYC,
  input  wire logic                     I_WB_STB,
  input  wire logic                     I_WB_WE,
  input  wire logic [7:0]               I_WB_ADR,
  input  wire logic [3:0]               I_WB_SEL,
  input  wire logic [31:0]              I_WB_DAT,
  output var  logic [31:0]              O_WB_DAT,
  output var  logic                     O_WB_ACK,
  input  wire logic [`EIIC_NUM_DED-1:0] I_DEDICATED_REQUEST_PIN,
  input  wire logic [`EIIC_NUM_PG-1:0]  I_PIN_GROUP_REQUEST_PIN,
  input  wire logic [`EIIC_NUM_INT-1:0] I_INTERNAL_REQ,
  input  wire logic                     I_MASK_BIT,
  input  wire logic                     I_INSN_DONE,
  input  wire logic [15:0]              I_VEC_DATA,
  output var  logic                     O_SAVE_CTX,
  output var  logic                     O_SET_MASK,
  output var  logic                     O_VEC_FETCH,
  output var  logic [15:0]              O_VEC_ADDR,
  output var  logic                     O_HANDLER_START,
  output var  logic [15:0]              O_HANDLER_ADDR,
  output var  logic [4:0]               O_VEC_NUM
);

  import eiic_pkg::*;

  eiic_state_t              st_reg;
  eiic_state_t              st_next;
  logic [`EIIC_NUM_DED-1:0] ded_edge;
  logic [`EIIC_NUM_PG-1:0]  pg_edge;
  logic [`EIIC_NUM_SRC-1:0] pending;
  logic                     sel_valid;
  logic [4:0]               sel_vector;
  logic                     bus_req;
  logic                     wr_now;
  logic [3:0]               wr_idx;
  logic [3:0]               rd_idx;
  logic [31:0]              rd_word;
  logic [31:0]              wmask;
  logic                     take;
  logic [`EIIC_NUM_DED-1:0] ded_pend;
  logic                     pg_pend;
  logic [`EIIC_NUM_INT-1:0] int_pend;
  logic                     clr_ded;
  logic                     clr_pg;
  logic                     clr_int;
  logic                     accept;

  ////////////////////////////////////////////////////////////////////
  // Register index from byte address, 4'hF when unmapped
  function automatic logic [3:0] reg_index(input logic [7:0] adr);
    if (adr == `EIIC_OFS_EDGE1)
      return 4'h0;
    else if (adr == `EIIC_OFS_EDGE2)
      return 4'h1;
    else if (adr == `EIIC_OFS_PORT_MODE)
      return 4'h2;
    else if (adr == `EIIC_OFS_ENABLE1)
      return 4'h3;
    else if (adr == `EIIC_OFS_ENABLE3)
      return 4'h4;
    else if (adr == `EIIC_OFS_INT_ENABLE)
      return 4'h5;
    else if (adr == `EIIC_OFS_FLAGS1)
      return 4'h6;
    else if (adr == `EIIC_OFS_FLAGS3)
      return 4'h7;
    else if (adr == `EIIC_OFS_INT_FLAGS)
      return 4'h8;
    else if (adr == `EIIC_OFS_STATUS)
      return 4'h9;
    else
      return 4'hF;
  endfunction : reg_index

  // Merge byte-enabled write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    return (old & ~m) | (wd & m);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////
  // Edge detectors for the twelve external pins
  eiic_edge_detect #(
    .N (`EIIC_NUM_DED)
  ) u_ded_edge (
    .i_clk      (I_CORE_CLK),
    .i_reset    (I_RESET),
    .i_pin      (I_DEDICATED_REQUEST_PIN),
    .i_rise_sel (st_reg.ded_edge_sel),
    .o_edge     (ded_edge)
  ); // R4 R5

  // Pin-group pins, edge per second select register
  eiic_edge_detect #(
    .N (`EIIC_NUM_PG)
  ) u_pg_edge (
    .i_clk      (I_CORE_CLK),
    .i_reset    (I_RESET),
    .i_pin      (I_PIN_GROUP_REQUEST_PIN),
    .i_rise_sel (st_reg.pg_edge_sel),
    .o_edge     (pg_edge)
  ); // R4 R9

  ////////////////////////////////////////////////////////////////////
  // Enabled and flagged sources, grouped
  assign ded_pend = st_reg.ded_flags & st_reg.ded_enable;              // R7
  assign pg_pend  = |(st_reg.pg_flags & st_reg.pg_enable);             // R10 R11
  assign int_pend = st_reg.int_flags & st_reg.int_enable;              // R13

  // Index 0 is the highest priority
  assign pending  = {int_pend, pg_pend, ded_pend};

  // Fixed-order winner among pending sources
  eiic_prio_enc #(
    .N (`EIIC_NUM_SRC)
  ) u_prio (
    .i_pending (pending),
    .o_valid   (sel_valid),
    .o_vector  (sel_vector)
  ); // R15

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  assign bus_req = I_WB_CYC & I_WB_STB;
  assign wr_now  = bus_req & I_WB_WE & st_reg.ack;
  assign wr_idx  = reg_index(I_WB_ADR);
  assign rd_idx  = reg_index(I_WB_ADR);
  assign wmask   = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                    {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

  // One request taken per access
  assign take    = bus_req & ~st_reg.ack;

  // Write-0 clear strobes per flag register
  assign clr_ded = wr_now & (wr_idx == 4'h6);
  assign clr_pg  = wr_now & (wr_idx == 4'h7);
  assign clr_int = wr_now & (wr_idx == 4'h8);

  // Acceptance: unmasked winner at an instruction boundary
  assign accept  = sel_valid & ~I_MASK_BIT & I_INSN_DONE
                 & (st_reg.phase == EIIC_IDLE);                        // R14 R16 R17

  // Read multiplexer, narrow registers zero-extended
  always_comb
  begin
    rd_word = `EIIC_RST_WORD;
    case (rd_idx)
      4'h0: rd_word[`EIIC_NUM_DED-1:0] = st_reg.ded_edge_sel;
      4'h1: rd_word[`EIIC_NUM_PG-1:0]  = st_reg.pg_edge_sel;
      4'h2: rd_word[`EIIC_NUM_DED-1:0] = st_reg.port_mode;
      4'h3: rd_word[`EIIC_NUM_DED-1:0] = st_reg.ded_enable;
      4'h4: rd_word[`EIIC_NUM_PG-1:0]  = st_reg.pg_enable;
      4'h5: rd_word[`EIIC_NUM_INT-1:0] = st_reg.int_enable;
      4'h6: rd_word[`EIIC_NUM_DED-1:0] = st_reg.ded_flags;
      4'h7: rd_word[`EIIC_NUM_PG-1:0]  = st_reg.pg_flags;              // R11
      4'h8: rd_word[`EIIC_NUM_INT-1:0] = st_reg.int_flags;
      4'h9:
      begin
        rd_word[0]    = I_MASK_BIT;
        rd_word[1]    = (st_reg.phase != EIIC_IDLE);
        rd_word[6:2]  = st_reg.vec_num;
        rd_word[11:7] = sel_vector;
        rd_word[12]   = sel_valid;
      end
      default: rd_word = `EIIC_RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state: bus slave, flags, exception entry
  always_comb
  begin
    logic [31:0] clr;
    clr     = 32'hFFFF_FFFF;
    st_next = st_reg;

    // Classic single-wait-state acknowledge with registered data
    st_next.ack   = take;
    st_next.rdata = take ? rd_word : `EIIC_RST_WORD;

    // Control register writes at the acknowledge edge
    if (wr_now)
    begin
      case (wr_idx)
        4'h0: st_next.ded_edge_sel = 4'(merge(32'(st_reg.ded_edge_sel), I_WB_DAT,
                                              wmask));
        4'h1: st_next.pg_edge_sel  = 8'(merge(32'(st_reg.pg_edge_sel), I_WB_DAT,
                                              wmask));
        4'h2: st_next.port_mode    = 4'(merge(32'(st_reg.port_mode), I_WB_DAT,
                                              wmask));
        4'h3: st_next.ded_enable   = 4'(merge(32'(st_reg.ded_enable), I_WB_DAT,
                                              wmask));
        4'h4: st_next.pg_enable    = 8'(merge(32'(st_reg.pg_enable), I_WB_DAT,
                                              wmask));
        4'h5: st_next.int_enable   = 21'(merge(32'(st_reg.int_enable), I_WB_DAT,
                                               wmask));
        default:
        begin
          // Flags, status, unmapped: no control write
          st_next.ack = take;
        end
      endcase
    end

    // Flag writes: zero in an enabled lane clears, one keeps
    if (wr_now)
      clr = I_WB_DAT | ~wmask;                                         // R2

    // Set beats clear in the same cycle; acceptance leaves flags alone
    st_next.ded_flags = st_reg.ded_flags
                        & (clr_ded ? clr[`EIIC_NUM_DED-1:0]
                                   : {`EIIC_NUM_DED{1'b1}})
                        | (ded_edge & st_reg.port_mode);               // R6 R21

    // Pin-group flags set on any selected edge
    st_next.pg_flags  = st_reg.pg_flags
                        & (clr_pg ? clr[`EIIC_NUM_PG-1:0]
                                  : {`EIIC_NUM_PG{1'b1}})
                        | pg_edge;                                     // R1 R12 R21

    // Internal flags set by each request pulse
    st_next.int_flags = st_reg.int_flags
                        & (clr_int ? clr[`EIIC_NUM_INT-1:0]
                                   : {`EIIC_NUM_INT{1'b1}})
                        | I_INTERNAL_REQ;                              // R13 R21

    // One-cycle strobes default low
    st_next.set_mask      = 1'b0;
    st_next.handler_start = 1'b0;

    // Exception entry sequencer
    case (st_reg.phase)
      EIIC_IDLE:
      begin
        // Accept at an instruction boundary only while unmasked
        if (accept)                                                    // R16
        begin
          st_next.phase    = EIIC_SAVE;
          st_next.cnt      = `EIIC_SAVE_CYC;                           // R22
          st_next.vec_num  = sel_vector;
          st_next.save_ctx = 1'b1;                                     // R17
          st_next.set_mask = 1'b1;                                     // R18
        end
      end

      // Stack save of counter and codes
      EIIC_SAVE:
      begin
        if (st_reg.cnt == 4'h0)
        begin
          st_next.phase     = EIIC_VFETCH;
          st_next.cnt       = `EIIC_VEC_CYC;                           // R22
          st_next.save_ctx  = 1'b0;
          st_next.vec_fetch = 1'b1;                                    // R19
          st_next.vec_addr  = {10'h000, st_reg.vec_num, 1'b0};         // R19
        end
        else
          st_next.cnt = st_reg.cnt - 4'h1;
      end

      // Vector fetch, handler taken on last state
      EIIC_VFETCH:
      begin
        if (st_reg.cnt == 4'h0)
        begin
          st_next.phase     = EIIC_IFETCH;
          st_next.cnt       = `EIIC_IFETCH_CYC;                        // R22
          st_next.vec_fetch = 1'b0;
          st_next.handler   = I_VEC_DATA;                              // R19
        end
        else
          st_next.cnt = st_reg.cnt - 4'h1;
      end

      // Handler instruction fetch
      EIIC_IFETCH:
      begin
        if (st_reg.cnt == 4'h0)
        begin
          st_next.phase = EIIC_INTPROC;
          st_next.cnt   = `EIIC_INTPROC_CYC;                           // R22
        end
        else
          st_next.cnt = st_reg.cnt - 4'h1;
      end

      // Internal processing, then start
      EIIC_INTPROC:
      begin
        if (st_reg.cnt == 4'h0)
        begin
          st_next.phase         = EIIC_IDLE;
          st_next.handler_start = 1'b1;                                // R19 R22
        end
        else
          st_next.cnt = st_reg.cnt - 4'h1;
      end

      // Unused phase codes fall back to idle
      default:
        st_next.phase = EIIC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register, all cleared on reset
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      st_reg          <= '0;
      st_reg.phase    <= EIIC_IDLE;
      st_reg.pg_flags <= `EIIC_RST_BYTE;                               // R3
    end
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign O_WB_DAT        = st_reg.rdata;
  assign O_WB_ACK        = st_reg.ack;

  // Entry strobes and handler address to the core
  assign O_SAVE_CTX      = st_reg.save_ctx;
  assign O_SET_MASK      = st_reg.set_mask;
  assign O_VEC_FETCH     = st_reg.vec_fetch;
  assign O_VEC_ADDR      = st_reg.vec_addr;
  assign O_HANDLER_START = st_reg.handler_start;
  assign O_HANDLER_ADDR  = st_reg.handler;
  assign O_VEC_NUM       = st_reg.vec_num;

endmodule : eiic_top

`default_nettype wire

// ---- verification/eiic_top_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module eiic_top_chk (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RESET,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_MASK_BIT,
  input wire logic        I_INSN_DONE,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        O_SAVE_CTX,
  input wire logic        O_SET_MASK,
  input wire logic        O_VEC_FETCH,
  input wire logic [15:0] O_VEC_ADDR,
  input wire logic        O_HANDLER_START,
  input wire logic [4:0]  O_VEC_NUM
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  ////////////////////////////////////////////////////////////////////////////////
  // Register bus handshake
  a_ack_next: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("bus ack missing one cycle after request");
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("bus ack longer than one cycle");
  a_dat_idle: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0000_0000)
    else $error("read data not zero outside ack");
  ////////////////////////////////////////////////////////////////////////////////
  // Exception entry
  a_entry_gate: assert property ($rose(O_SAVE_CTX) |-> $past(I_INSN_DONE) && !$past(I_MASK_BIT))
    else $error("entry without boundary or while masked");
  a_mask_set: assert property ($rose(O_SAVE_CTX) |-> O_SET_MASK)
    else $error("mask not set at entry");
  a_save_seq: assert property ($rose(O_SAVE_CTX) |-> O_SAVE_CTX[*4] ##1
    (O_VEC_FETCH && !O_SAVE_CTX)[*2] ##1 !O_VEC_FETCH)
    else $error("save or fetch phase length wrong");
  a_entry_time: assert property ($rose(O_SAVE_CTX) |-> !O_HANDLER_START ##14 O_HANDLER_START)
    else $error("handler start not 14 cycles after save");
  a_vec_addr: assert property (O_VEC_FETCH |-> O_VEC_ADDR == {10'h000, O_VEC_NUM, 1'b0})
    else $error("vector address not twice vector number");
  a_vec_range: assert property ($rose(O_SAVE_CTX) |-> O_VEC_NUM >= 5'h04 && O_VEC_NUM <= 5'h17)
    else $error("accepted vector out of range");
endmodule : eiic_top_chk
bind eiic_top eiic_top_chk i_chk (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_MASK_BIT(I_MASK_BIT),
  .I_INSN_DONE(I_INSN_DONE), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
  .O_SAVE_CTX(O_SAVE_CTX), .O_SET_MASK(O_SET_MASK), .O_VEC_FETCH(O_VEC_FETCH),
  .O_VEC_ADDR(O_VEC_ADDR), .O_HANDLER_START(O_HANDLER_START), .O_VEC_NUM(O_VEC_NUM));
`default_nettype wire

// ---- verification/eiic_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module eiic_cpu_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_set_mask,
  input  wire logic        i_vec_fetch,
  input  wire logic [15:0] i_vec_addr,
  input  wire logic        i_handler_start,
  input  wire logic        i_rte,
  input  wire logic [3:0]  i_len,
  output var  logic        o_mask,
  output var  logic        o_insn_done,
  output var  logic [15:0] o_vec_data
);
  logic        busy;
  logic [3:0]  cnt;
  logic [15:0] pat;
  // Mask bit, entry tracking, instruction pacing
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_mask <= 1'b1;
      busy   <= 1'b0;
      cnt    <= 4'h0;
      pat    <= 16'h5A5A;
    end
    else
    begin
      pat <= ~pat; // Table idle: changes every cycle
      cnt <= (cnt >= i_len) ? 4'h0 : cnt + 4'h1;
      if (i_set_mask)
        o_mask <= 1'b1;
      else if (i_rte)
        o_mask <= 1'b0;
      if (i_set_mask)
        busy <= 1'b1;
      else if (i_handler_start)
        busy <= 1'b0;
    end
  end
  // No boundaries while entry runs
  assign o_insn_done = !busy && (cnt == 4'h0);
  // Vector table: handler at A000 plus vector address
  assign o_vec_data = i_vec_fetch ? (16'hA000 | i_vec_addr) : pat;
endmodule : eiic_cpu_model
`default_nettype wire

// ---- verification/external_internal_interrupt_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module external_internal_interrupt_control_tb;
  import eiic_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  ded = 4'hF;
  logic [7:0]  pg = 8'hF0;
  logic [20:0] ireq = '0;
  logic        rte = 1'b0;
  logic        mask, idone, sctx, smask, vf, hst;
  logic [15:0] vdat, vadr, hadr;
  logic [4:0]  vnum;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n_ent = 0;
  eiic_top i_eiic_top (.I_CORE_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(dat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_DEDICATED_REQUEST_PIN(ded), .I_PIN_GROUP_REQUEST_PIN(pg),
    .I_INTERNAL_REQ(ireq), .I_MASK_BIT(mask), .I_INSN_DONE(idone), .I_VEC_DATA(vdat),
    .O_SAVE_CTX(sctx), .O_SET_MASK(smask), .O_VEC_FETCH(vf), .O_VEC_ADDR(vadr),
    .O_HANDLER_START(hst), .O_HANDLER_ADDR(hadr), .O_VEC_NUM(vnum));
  eiic_cpu_model i_eiic_cpu_model (.i_clk(clk), .i_reset(rst), .i_set_mask(smask),
    .i_vec_fetch(vf), .i_vec_addr(vadr), .i_handler_start(hst), .i_rte(rte),
    .i_len(4'h3), .o_mask(mask), .o_insn_done(idone), .o_vec_data(vdat));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #25 clk = ~clk;
  // Entry count and hang guard
  always @(posedge clk)
  begin
    if (hst === 1'b1) n_ent++;
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("Error timeout exp done seen hang");
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    chk("bus_ack", n, 2);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, e);
  endtask : rd
  task automatic ent(input logic [4:0] ev);
    int n;
    n = 0;
    while (hst !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    chk("entry", 32'(hst), 32'h0000_0001);
    chk("vec_num", 32'(vnum), 32'(ev));
    chk("handler", 32'(hadr), 32'(16'hA000 | {10'h000, ev, 1'b0}));
  endtask : ent
  task automatic quiet(input string nm);
    int e;
    e = n_ent;
    repeat (40) @(posedge clk);
    chk(nm, n_ent, e);
  endtask : quiet
  task automatic clr_i();
    rte <= 1'b1;
    @(posedge clk);
    rte <= 1'b0;
    @(posedge clk);
  endtask : clr_i
  task automatic end_sim();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("ded_flags", 8'h18, 32'h0000_0000);
    rd("grp_flags", 8'h1C, 32'h0000_0000);
    rd("int_flags", 8'h20, 32'h0000_0000);
    rd("unmapped", 8'h30, 32'h0000_0000);
    $display("test reset done");
    wr(8'h04, 32'h0000_000F);
    wr(8'h1C, 32'h0000_00FF);
    rd("grp_w1", 8'h1C, 32'h0000_0000);
    pg <= 8'h0F;
    repeat (5) @(posedge clk);
    rd("grp_edge", 8'h1C, 32'h0000_00FF);
    wr(8'h1C, 32'h0000_0000);
    pg <= 8'hF0;
    repeat (5) @(posedge clk);
    rd("grp_other", 8'h1C, 32'h0000_0000);
    clr_i();
    pg <= 8'h0F;
    quiet("grp_off");
    wr(8'h1C, 32'h0000_0000);
    $display("test group done");
    ded <= 4'h0;
    repeat (5) @(posedge clk);
    rd("ded_nomode", 8'h18, 32'h0000_0000);
    ded <= 4'hF;
    wr(8'h08, 32'h0000_000F);
    ded <= 4'h0;
    quiet("ded_off");
    rd("ded_fall", 8'h18, 32'h0000_000F);
    wr(8'h0C, 32'h0000_000F);
    for (int n = 0; n < 4; n++)
    begin
      ent(5'(4 + n));
      rd("ded_keep", 8'h18, 32'(4'(4'hF << n)));
      wr(8'h18, 32'(4'hF & ~(4'h1 << n)));
      if (n == 0) quiet("masked");
      clr_i();
    end
    $display("test dedicated done");
    wr(8'h10, 32'h0000_00FF);
    pg <= 8'h0E;
    repeat (5) @(posedge clk);
    pg <= 8'h0F;
    ent(5'h08);
    rd("grp_src", 8'h1C, 32'h0000_0001);
    wr(8'h1C, 32'h0000_0000);
    clr_i();
    wr(8'h14, 32'h0010_0001);
    ireq <= 21'h10_0000;
    @(posedge clk);
    ireq <= '0;
    ent(5'h17);
    rd("int_src", 8'h20, 32'h0010_0000);
    wr(8'h20, 32'h0000_0000);
    clr_i();
    ireq <= 21'h00_0001;
    @(posedge clk);
    ireq <= '0;
    ent(5'h09);
    wr(8'h20, 32'h0000_0000);
    $display("test internal done");
    end_sim();
  end
endmodule : external_internal_interrupt_control_tb
`default_nettype wire
